/* rtl/icms_pkg.sv */
// Purpose: Shared constants and types for input clock monitor and select
// Assumes: Three-level straps arrive as a two-bit code per pin
// Notes: Code 2'b11 means the pin is left floating
package icms_pkg;
   // Three-level pin codes
   localparam logic [1:0] ICMS_LVL_L = 2'h0;
   localparam logic [1:0] ICMS_LVL_M = 2'h1;
   localparam logic [1:0] ICMS_LVL_H = 2'h2;
   localparam logic [1:0] ICMS_LVL_FLOAT = 2'h3;
   // Selection policy codes
   localparam logic [1:0] ICMS_POL_MANUAL = 2'h0;
   localparam logic [1:0] ICMS_POL_AUTO_NR = 2'h1;
   localparam logic [1:0] ICMS_POL_AUTO_REV = 2'h2;
   // Monitor timing, in system clock cycles (valid count in reference edges)
   localparam int ICMS_GAP_W = 8;
   localparam logic [ICMS_GAP_W-1:0] ICMS_LOS_LIMIT_L = 8'h10;
   localparam logic [ICMS_GAP_W-1:0] ICMS_LOS_LIMIT_M = 8'h20;
   localparam logic [ICMS_GAP_W-1:0] ICMS_LOS_LIMIT_H = 8'h40;
   localparam int ICMS_GOOD_W = 4;
   localparam logic [ICMS_GOOD_W-1:0] ICMS_VALID_EDGES = 4'h8;
   localparam int ICMS_CAL_W = 8;
   localparam logic [ICMS_CAL_W-1:0] ICMS_CAL_CYCLES = 8'h40;
   // Crystal rate decode
   localparam int ICMS_RATE_W = 4;
   localparam logic [ICMS_RATE_W-1:0] ICMS_RATE_RESET = 4'h4;
   localparam logic [1:0] ICMS_EXT_CLK_HI_LVL = 2'h2;

   typedef struct packed {
      logic lost;
      logic [ICMS_GOOD_W-1:0] good;
      logic [ICMS_GAP_W-1:0] gap;
      logic prev;
   } icms_mon_t;

   typedef struct packed {
      logic ext_clk;
      logic [ICMS_RATE_W-1:0] rate;
   } icms_xtal_t;

   typedef enum logic [1:0] {ICMS_CAL_WAIT, ICMS_CAL_RUN, ICMS_CAL_DONE} icms_cal_t;
endpackage

/* rtl/icms_input_clock_monitor_select.sv */
// Purpose: Loss-of-signal monitors, input selection and strap decode
// Assumes: Reference clocks are sampled as synchronous inputs
// Notes: Rate and table straps are captured on the first cycle after reset
module icms_input_clock_monitor_select (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ref_clock_in_a,
   input wire logic ref_clock_in_b,
   input wire logic [1:0] select_policy_strap_in,
   input wire logic [1:0] xtal_rate_strap_lo_in,
   input wire logic [1:0] xtal_rate_strap_hi_in,
   input wire logic [1:0] freq_table_strap_in,
   input wire logic manual_select_in,
   output logic in1_loss_flag_out,
   output logic in2_loss_flag_out,
   output logic active_input_out,
   output logic [1:0] select_policy_out,
   output icms_pkg::icms_xtal_t xtal_cfg_out,
   output logic calib_done_out
);
   import icms_pkg::*;

   function automatic logic [1:0] icms_lvl(input logic [1:0] code);
      icms_lvl = (code == ICMS_LVL_FLOAT) ? ICMS_LVL_M : code;
   endfunction

   logic [1:0] clk_in;
   logic [1:0] edge_det;
   logic [1:0] lost;
   icms_mon_t mon_q [2];
   icms_mon_t mon_d [2];
   logic [ICMS_GAP_W-1:0] limit_q, limit_d;
   icms_xtal_t xtal_q, xtal_d;
   logic capture_q, capture_d;
   logic [1:0] policy_q, policy_d;
   logic active_q, active_d;
   icms_cal_t cal_q, cal_d;
   logic [ICMS_CAL_W-1:0] cal_cnt_q, cal_cnt_d;

   assign clk_in = {ref_clock_in_b, ref_clock_in_a};

   // Strap capture and decode
   always_comb begin
      logic [1:0] lo;
      logic [1:0] hi;
      lo = icms_lvl(xtal_rate_strap_lo_in);
      hi = icms_lvl(xtal_rate_strap_hi_in);
      capture_d = 1'b0;
      xtal_d = xtal_q;
      limit_d = limit_q;
      if (capture_q) begin
         xtal_d.rate = ICMS_RATE_W'(hi) * 4'h3 + ICMS_RATE_W'(lo);
         xtal_d.ext_clk = (hi == ICMS_EXT_CLK_HI_LVL);
         case (icms_lvl(freq_table_strap_in))
            ICMS_LVL_L: limit_d = ICMS_LOS_LIMIT_L;
            ICMS_LVL_H: limit_d = ICMS_LOS_LIMIT_H;
            default: limit_d = ICMS_LOS_LIMIT_M;
         endcase
      end
      policy_d = icms_lvl(select_policy_strap_in);
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         capture_q <= 1'b1;
         xtal_q <= '{ext_clk: 1'b0, rate: ICMS_RATE_RESET};
         limit_q <= ICMS_LOS_LIMIT_M;
         policy_q <= ICMS_POL_AUTO_NR;
      end else begin
         capture_q <= capture_d;
         xtal_q <= xtal_d;
         limit_q <= limit_d;
         policy_q <= policy_d;
      end
   end

   // Per-input loss-of-signal monitors
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_mon
         assign edge_det[gi] = clk_in[gi] & ~mon_q[gi].prev;
         assign lost[gi] = mon_q[gi].lost;

         always_comb begin
            mon_d[gi] = mon_q[gi];
            mon_d[gi].prev = clk_in[gi];
            if (edge_det[gi]) begin
               mon_d[gi].gap = '0;
               if (mon_q[gi].lost) begin
                  if (mon_q[gi].good == ICMS_VALID_EDGES - 4'h1) begin
                     mon_d[gi].lost = 1'b0;
                     mon_d[gi].good = '0;
                  end else begin
                     mon_d[gi].good = mon_q[gi].good + 4'h1;
                  end
               end
            end else if (mon_q[gi].gap >= limit_q - 8'h1) begin
               mon_d[gi].lost = 1'b1;
               mon_d[gi].good = '0;
            end else begin
               mon_d[gi].gap = mon_q[gi].gap + 8'h1;
            end
         end

         always_ff @(posedge clk_sys_in) begin
            if (rst_in) begin
               mon_q[gi] <= '{lost: 1'b1, good: '0, gap: '0, prev: 1'b0};
            end else begin
               mon_q[gi] <= mon_d[gi];
            end
         end

         loss_set_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
            (!edge_det[gi] && mon_q[gi].gap == limit_q - 8'h1) |=> mon_q[gi].lost)
            else $error("loss flag not raised at gap limit");
         loss_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
            (mon_q[gi].lost && !edge_det[gi]) |=> mon_q[gi].lost)
            else $error("loss flag dropped without an edge");
         loss_clear_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
            (mon_q[gi].lost ##1 !mon_q[gi].lost) |-> $past(mon_q[gi].good) == ICMS_VALID_EDGES - 4'h1)
            else $error("loss flag cleared before validation");
      end
   endgenerate

   // Input selection and calibration
   always_comb begin
      active_d = active_q;
      case (policy_q)
         ICMS_POL_MANUAL: active_d = manual_select_in;
         ICMS_POL_AUTO_REV: begin
            if (!lost[0]) begin
               active_d = 1'b0;
            end else if (!lost[1]) begin
               active_d = 1'b1;
            end
         end
         default: begin
            if (lost[active_q] && !lost[~active_q]) begin
               active_d = ~active_q;
            end
         end
      endcase
      cal_d = cal_q;
      cal_cnt_d = cal_cnt_q;
      case (cal_q)
         ICMS_CAL_WAIT: begin
            if (!lost[active_q]) begin
               cal_d = ICMS_CAL_RUN;
            end
         end
         ICMS_CAL_RUN: begin
            cal_cnt_d = cal_cnt_q + 8'h1;
            if (cal_cnt_q == ICMS_CAL_CYCLES - 8'h1) begin
               cal_d = ICMS_CAL_DONE;
            end
         end
         ICMS_CAL_DONE: cal_d = ICMS_CAL_DONE;
         default: cal_d = ICMS_CAL_WAIT;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         active_q <= 1'b0;
         cal_q <= ICMS_CAL_WAIT;
         cal_cnt_q <= '0;
      end else begin
         active_q <= active_d;
         cal_q <= cal_d;
         cal_cnt_q <= cal_cnt_d;
      end
   end

   // Output registers
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         in1_loss_flag_out <= 1'b1;
         in2_loss_flag_out <= 1'b1;
         active_input_out <= 1'b0;
         select_policy_out <= ICMS_POL_AUTO_NR;
         xtal_cfg_out <= '{ext_clk: 1'b0, rate: ICMS_RATE_RESET};
         calib_done_out <= 1'b0;
      end else begin
         in1_loss_flag_out <= lost[0];
         in2_loss_flag_out <= lost[1];
         active_input_out <= active_q;
         select_policy_out <= policy_q;
         xtal_cfg_out <= xtal_q;
         calib_done_out <= (cal_q == ICMS_CAL_DONE);
      end
   end

   policy_float_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (select_policy_strap_in == ICMS_LVL_FLOAT) |=> ##1 (select_policy_out == ICMS_POL_AUTO_NR))
      else $error("floating policy strap not read as middle");
   policy_decode_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (select_policy_strap_in != ICMS_LVL_FLOAT) |=> (policy_q == $past(select_policy_strap_in)))
      else $error("policy strap decoded wrongly");
   rate_float_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (capture_q && xtal_rate_strap_lo_in == ICMS_LVL_L && xtal_rate_strap_hi_in == ICMS_LVL_FLOAT)
      |=> (xtal_q.rate == 4'h3 && !xtal_q.ext_clk))
      else $error("floating rate straps not read as middle");
   rate_type_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (capture_q && xtal_rate_strap_hi_in == ICMS_LVL_H) |=> ##1 xtal_cfg_out.ext_clk)
      else $error("external reference kind not decoded");
   plan_limit_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (capture_q && freq_table_strap_in == ICMS_LVL_L) |=> (limit_q == ICMS_LOS_LIMIT_L))
      else $error("plan table limit not taken");
   revert_pref_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (policy_q == ICMS_POL_AUTO_REV && !lost[0]) |=> !active_q)
      else $error("revertive mode did not return to input one");
   nonrev_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (policy_q == ICMS_POL_AUTO_NR && !lost[active_q]) |=> $stable(active_q))
      else $error("non-revertive mode left a good input");
   reset_state_a: assert property (@(posedge clk_sys_in)
      rst_in |=> (in1_loss_flag_out && in2_loss_flag_out && !calib_done_out && cal_q == ICMS_CAL_WAIT))
      else $error("reset state not reached");
endmodule

/* bench/icms_board_model.sv */
// Purpose: Board side: two input clock sources
// Assumes: Sources run from one divider
// Notes: A stopped source stays stuck at its last level
module icms_board_model (
   input wire logic clk_sys_in,
   input wire logic run_a_in,
   input wire logic run_b_in,
   output logic ref_a_out,
   output logic ref_b_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic div_q;
   initial begin
      div_q = 1'b0;
      ref_a_out = 1'b0;
      ref_b_out = 1'b0;
   end
   // Shared divider, equal rate on both inputs
   always @(posedge clk_sys_in) begin
      div_q <= #1 ~div_q;
      if (div_q && run_a_in) ref_a_out <= #1 ~ref_a_out;
      if (div_q && run_b_in) ref_b_out <= #1 ~ref_b_out;
   end
endmodule

/* bench/testbench.sv */
// Purpose: Self-checking bench for input clock monitor and select
// Assumes: Inputs change 1 ns after the rising edge
// Notes: One task per scenario
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import icms_pkg::*;
   logic clk_sys_in, rst_in, run_a, run_b, man_sel, ra, rb, f1, f2, act, cal;
   logic [1:0] pol_s, lo_s, hi_s, tbl_s, pol_o;
   icms_xtal_t xc;
   int num_errors, n_tests;
   initial begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   icms_board_model board (.clk_sys_in(clk_sys_in), .run_a_in(run_a), .run_b_in(run_b),
      .ref_a_out(ra), .ref_b_out(rb));
   icms_input_clock_monitor_select DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .ref_clock_in_a(ra), .ref_clock_in_b(rb), .select_policy_strap_in(pol_s),
      .xtal_rate_strap_lo_in(lo_s), .xtal_rate_strap_hi_in(hi_s), .freq_table_strap_in(tbl_s),
      .manual_select_in(man_sel), .in1_loss_flag_out(f1), .in2_loss_flag_out(f2),
      .active_input_out(act), .select_policy_out(pol_o), .xtal_cfg_out(xc), .calib_done_out(cal));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("errors=%0d checks=%0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return f1;
         1: return f2;
         2: return act;
         default: return cal;
      endcase
   endfunction
   task automatic wait_for(input int s, input logic v, input int lim);
      for (int i = 0; i < lim && pick(s) !== v; i++) cyc(1);
      check(pick(s), v);
      if (pick(s) !== v) final_report();
   endtask
   task automatic do_reset(input logic [1:0] lo, input logic [1:0] hi, input logic [1:0] tbl);
      lo_s = lo;
      hi_s = hi;
      tbl_s = tbl;
      rst_in = 1'b1;
      cyc(16);
      check({f1, f2, cal}, 8'h06);
      check(xc, 8'h04);
      rst_in = 1'b0;
      cyc(4);
   endtask
   task automatic t_strap();
      do_reset(2'h2, 2'h0, 2'h3);
      check(xc, 8'h02);
      lo_s = 2'h0;
      cyc(4);
      check(xc, 8'h02);
      do_reset(2'h3, 2'h2, 2'h3);
      check(xc, 8'h17);
      do_reset(2'h0, 2'h3, 2'h3);
      check(xc, 8'h03);
   endtask
   task automatic t_valid();
      wait_for(0, 1'b0, 100);
      wait_for(1, 1'b0, 100);
      wait_for(3, 1'b1, 200);
   endtask
   task automatic t_loss_b();
      run_b = 1'b0;
      cyc(24);
      check(f2, 1'b0);
      cyc(16);
      check(f2, 1'b1);
      run_b = 1'b1;
      cyc(20);
      check(f2, 1'b1);
      run_b = 1'b0;
      cyc(40);
      check(f2, 1'b1);
      run_b = 1'b1;
      cyc(20);
      check(f2, 1'b1);
      wait_for(1, 1'b0, 60);
   endtask
   task automatic t_policy();
      logic [1:0] exp [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
      for (int c = 0; c < 4; c++) begin
         pol_s = c[1:0];
         cyc(3);
         check(pol_o, exp[c]);
      end
   endtask
   task automatic t_select();
      pol_s = 2'h2;
      run_a = 1'b0;
      wait_for(2, 1'b1, 60);
      run_a = 1'b1;
      wait_for(2, 1'b0, 60);
      pol_s = 2'h1;
      run_a = 1'b0;
      wait_for(2, 1'b1, 60);
      run_a = 1'b1;
      wait_for(0, 1'b0, 60);
      cyc(4);
      check(act, 1'b1);
      pol_s = 2'h0;
      cyc(4);
      check(act, 1'b0);
      man_sel = 1'b1;
      cyc(4);
      check(act, 1'b1);
   endtask
   task automatic t_table_low();
      do_reset(2'h0, 2'h0, 2'h0);
      wait_for(1, 1'b0, 100);
      run_b = 1'b0;
      cyc(10);
      check(f2, 1'b0);
      cyc(14);
      check(f2, 1'b1);
   endtask
   initial begin
      num_errors = 0;
      n_tests = 0;
      rst_in = 1'b1;
      {pol_s, lo_s, hi_s, tbl_s} = 8'hff;
      man_sel = 1'b0;
      run_a = 1'b1;
      run_b = 1'b1;
      t_strap();
      t_valid();
      t_loss_b();
      t_policy();
      t_select();
      t_table_low();
      final_report();
   end
endmodule
